//--- hdl/flag_bank_pkg.sv
// Package for the module-level latched flag bank: offsets, bit positions, widths and types.
package flag_bank_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Byte offsets in the management memory
  localparam logic [7:0] STATUS_OFS    = 8'h03;
  localparam logic [7:0] EVENT_OFS     = 8'h08;
  localparam logic [7:0] SUP_TEMP_OFS  = 8'h09;
  localparam logic [7:0] AUX12_OFS     = 8'h0a;
  localparam logic [7:0] AUX3_VEND_OFS = 8'h0b;
  localparam logic [7:0] RSVD_OFS      = 8'h0c;
  localparam logic [7:0] VEND_OFS      = 8'h0d;

  // Event byte bit positions
  localparam int unsigned MSG_TWO_BIT   = 7;
  localparam int unsigned MSG_ONE_BIT   = 6;
  localparam int unsigned SP_FW_BIT     = 2;
  localparam int unsigned MAIN_FW_BIT   = 1;
  localparam int unsigned STATE_BIT     = 0;
  localparam logic [7:0]  EVENT_DEFINED = 8'hc7;

  // Monitor nibble order: low warn, high warn, low alarm, high alarm (MSB first)
  localparam int unsigned NUM_MON     = 6;
  localparam int unsigned MON_TEMP    = 0;
  localparam int unsigned MON_SUPPLY  = 1;
  localparam int unsigned MON_AUX_A   = 2;
  localparam int unsigned MON_AUX_B   = 3;
  localparam int unsigned MON_AUX_C   = 4;
  localparam int unsigned MON_VENDOR  = 5;

  localparam logic [7:0] FLAG_RESET      = 8'h00;
  localparam logic       IRQ_STATUS_RST  = 1'b1;
  localparam logic [2:0] PHASE_RESET     = 3'h0;
  localparam int unsigned PHASE_W        = 3;

  // One threshold comparison result per monitor
  typedef struct packed {
    logic low_warn;
    logic high_warn;
    logic low_alarm;
    logic high_alarm;
  } threshold_t;

  // Host read port of the management memory
  typedef struct packed {
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
  } mgmt_read_t;

  // Non-threshold events
  typedef struct packed {
    logic msg_instance_two_done;
    logic msg_instance_one_done;
    logic signal_processor_fw_fail;
    logic main_fw_fail;
  } module_event_t;

  function automatic logic [3:0] pack_threshold(input threshold_t t);
    pack_threshold = {t.low_warn, t.high_warn, t.low_alarm, t.high_alarm};
  endfunction : pack_threshold
endpackage : flag_bank_pkg

//--- hdl/cor_flag_byte.sv
// One byte of latched, clear-on-read flags.
`timescale 1ns/1ps
module cor_flag_byte
  import flag_bank_pkg::*;
(
  input  wire logic              i_clock,  // Management clock
  input  wire logic              i_rst_n,  // Async reset, active low
  input  wire logic [DATA_W-1:0] i_set,    // Event pulses or levels
  input  wire logic [DATA_W-1:0] i_valid,  // Implemented bit mask
  input  wire logic              i_clear,  // Host read of this byte
  output logic      [DATA_W-1:0] o_flags   // Latched flags
);
  logic [DATA_W-1:0] flags_ff;
  logic [DATA_W-1:0] nxt_flags;

  genvar g;
  generate
    for (g = 0; g < DATA_W; g++)
    begin : g_bit
      // Set beats the read clear, so an event in the read cycle survives
      assign nxt_flags[g] = i_valid[g] & (i_set[g] | (flags_ff[g] & ~i_clear));
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flags_ff <= FLAG_RESET;
    else
      flags_ff <= nxt_flags;
  end

  assign o_flags = flags_ff;
endmodule : cor_flag_byte

//--- hdl/phase_change_detect.sv
// Detects changes of the module power phase code.
`timescale 1ns/1ps
module phase_change_detect
  import flag_bank_pkg::*;
(
  input  wire logic               i_clock,  // Management clock
  input  wire logic               i_rst_n,  // Async reset, active low
  input  wire logic [PHASE_W-1:0] i_phase,  // Current power phase code
  output logic                    o_change  // One-cycle pulse on change
);
  logic [PHASE_W-1:0] phase_ff;
  logic               armed_ff;

  // Arming skips the first compare so the reset value is not seen as a change
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase_ff <= PHASE_RESET;
      armed_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= i_phase;
      armed_ff <= 1'b1;
    end
  end

  assign o_change = armed_ff & (phase_ff != i_phase);
endmodule : phase_change_detect

//--- hdl/module_level_latched_flags.sv
// Module-level latched flag bank with clear-on-read host access.
`timescale 1ns/1ps
// Operation
// - Command-messaging completion for instance 2 latches in byte 8 bit 7 and instance 1 in bit 6.
// - Signal-processor firmware failure latches byte 8 bit 2.
// - Main firmware self-supervision failure latches byte 8 bit 1.
// - Any change of the module power phase latches byte 8 bit 0, which is always implemented.
// - Byte 8 bits 5 to 3 are reserved and always read zero.
// - Byte 9 bits 7 to 4 hold supply low warn, high warn, low alarm, high alarm.
// - Byte 9 bits 3 to 0 hold temperature low warn, high warn, low alarm, high alarm.
// - Byte 10 holds auxiliary monitor B flags high and auxiliary monitor A flags low.
// - Byte 11 holds vendor monitor flags high and auxiliary monitor C flags low.
// - Every defined flag is read-only, latched, and cleared by a host read of it.
// - All flags read cleared after reset and while nothing is faulty.
// - Byte 12 is reserved and byte 13 carries vendor custom flags.
// - Each thresholded monitor has its own alarm and warning flags.
// - The bank exists only in paged-memory builds; flat builds read it as zero.
// - Byte 3 bit 0 shows the interrupt output state, 1 meaning not asserted.
module module_level_latched_flags
  import flag_bank_pkg::*;
#(
  parameter bit PAGED_MEMORY = 1'b1  // Build option for the paged memory model
)
(
  input  wire logic               i_clock,        // Management clock, 250 MHz
  input  wire logic               i_rst_n,        // Async reset, active low
  input  wire mgmt_read_t         i_rd,           // Host read strobe and byte address
  input  wire module_event_t      i_event,        // Firmware and messaging events
  input  wire logic [PHASE_W-1:0] i_phase,        // Current power phase code
  input  wire threshold_t         i_thr [NUM_MON],// Threshold crossings per monitor
  input  wire logic [DATA_W-1:0]  i_vendor_set,   // Custom vendor flag events
  input  wire logic [DATA_W-1:0]  i_vendor_valid, // Implemented custom bits
  input  wire logic               i_irq_active,   // Interrupt output currently asserted
  output logic [DATA_W-1:0]       o_rd_data,      // Read data, registered
  output logic                    o_rd_valid,     // Read data valid pulse
  output logic                    o_any_flag      // Some flag in the bank is set
);
  localparam int unsigned NUM_BYTES = 5;
  localparam int unsigned B_EVENT   = 0;
  localparam int unsigned B_SUPTEMP = 1;
  localparam int unsigned B_AUX12   = 2;
  localparam int unsigned B_AUX3V   = 3;
  localparam int unsigned B_VEND    = 4;

  logic [DATA_W-1:0] set_vec   [NUM_BYTES];
  logic [DATA_W-1:0] valid_vec [NUM_BYTES];
  logic [DATA_W-1:0] flags     [NUM_BYTES];
  logic [NUM_BYTES-1:0] clr;
  logic              phase_change;
  logic [DATA_W-1:0] rd_data_ff;
  logic              rd_valid_ff;
  logic [DATA_W-1:0] nxt_rd_data;

  phase_change_detect u_phase
  (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_phase  (i_phase),
    .o_change (phase_change)
  );

  // Event byte
  always_comb
  begin
    set_vec[B_EVENT]              = 8'h00;
    set_vec[B_EVENT][MSG_TWO_BIT] = i_event.msg_instance_two_done;
    set_vec[B_EVENT][MSG_ONE_BIT] = i_event.msg_instance_one_done;
    set_vec[B_EVENT][SP_FW_BIT]   = i_event.signal_processor_fw_fail;
    set_vec[B_EVENT][MAIN_FW_BIT] = i_event.main_fw_fail;
    set_vec[B_EVENT][STATE_BIT]   = phase_change;
  end

  // Threshold bytes, one nibble per monitor
  assign set_vec[B_SUPTEMP] = {pack_threshold(i_thr[MON_SUPPLY]), pack_threshold(i_thr[MON_TEMP])};
  assign set_vec[B_AUX12]   = {pack_threshold(i_thr[MON_AUX_B]), pack_threshold(i_thr[MON_AUX_A])};
  assign set_vec[B_AUX3V]   = {pack_threshold(i_thr[MON_VENDOR]), pack_threshold(i_thr[MON_AUX_C])};
  assign set_vec[B_VEND]    = i_vendor_set;

  // Reserved event bits are masked so no event can land there
  assign valid_vec[B_EVENT]   = PAGED_MEMORY ? EVENT_DEFINED : 8'h00;
  assign valid_vec[B_SUPTEMP] = PAGED_MEMORY ? 8'hff : 8'h00;
  assign valid_vec[B_AUX12]   = PAGED_MEMORY ? 8'hff : 8'h00;
  assign valid_vec[B_AUX3V]   = PAGED_MEMORY ? 8'hff : 8'h00;
  assign valid_vec[B_VEND]    = PAGED_MEMORY ? i_vendor_valid : 8'h00;

  // Host read clears only the byte actually addressed
  assign clr[B_EVENT]   = i_rd.rd_en && (i_rd.addr == EVENT_OFS);
  assign clr[B_SUPTEMP] = i_rd.rd_en && (i_rd.addr == SUP_TEMP_OFS);
  assign clr[B_AUX12]   = i_rd.rd_en && (i_rd.addr == AUX12_OFS);
  assign clr[B_AUX3V]   = i_rd.rd_en && (i_rd.addr == AUX3_VEND_OFS);
  assign clr[B_VEND]    = i_rd.rd_en && (i_rd.addr == VEND_OFS);

  genvar g;
  generate
    for (g = 0; g < NUM_BYTES; g++)
    begin : g_byte
      cor_flag_byte u_byte
      (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_set   (set_vec[g]),
        .i_valid (valid_vec[g]),
        .i_clear (clr[g]),
        .o_flags (flags[g])
      );
    end
  endgenerate

  // Read mux returns the value held before the clear takes effect
  always_comb
  begin
    nxt_rd_data = 8'h00;
    case (i_rd.addr)
      STATUS_OFS:    nxt_rd_data = {7'h00, ~i_irq_active};
      EVENT_OFS:     nxt_rd_data = flags[B_EVENT];
      SUP_TEMP_OFS:  nxt_rd_data = flags[B_SUPTEMP];
      AUX12_OFS:     nxt_rd_data = flags[B_AUX12];
      AUX3_VEND_OFS: nxt_rd_data = flags[B_AUX3V];
      RSVD_OFS:      nxt_rd_data = 8'h00;
      VEND_OFS:      nxt_rd_data = flags[B_VEND];
      default:       nxt_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_data_ff  <= FLAG_RESET;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= i_rd.rd_en;
      if (i_rd.rd_en)
        rd_data_ff <= nxt_rd_data;
    end
  end

  assign o_rd_data  = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_any_flag = |{flags[B_EVENT], flags[B_SUPTEMP], flags[B_AUX12], flags[B_AUX3V], flags[B_VEND]};
endmodule : module_level_latched_flags

//--- dv/flag_bank_chk.sv
// Port-level assertions for the latched flag bank.
`timescale 1ns/1ps
module flag_bank_chk
  import flag_bank_pkg::*;
(
  input  wire logic              i_clock,         // Clock
  input  wire logic              i_rst_n,         // Reset, active low
  input  wire mgmt_read_t        i_rd,            // Host read
  input  wire module_event_t     i_event,         // Events
  input  wire threshold_t        i_thr [NUM_MON], // Thresholds
  input  wire logic              i_irq_active,    // Interrupt state
  input  wire logic [DATA_W-1:0] o_rd_data,       // Read data
  input  wire logic              o_rd_valid,      // Read valid
  input  wire logic              o_any_flag       // Any flag set
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_valid_after_read:
    assert property (i_rd.rd_en |=> o_rd_valid) else $error("no valid after read");
  a_valid_only_read:
    assert property (!i_rd.rd_en |=> !o_rd_valid) else $error("stray read valid");
  a_data_holds:
    assert property (!i_rd.rd_en |=> $stable(o_rd_data)) else $error("read data moved");
  a_irq_status_bit:
    assert property (i_rd.rd_en && i_rd.addr == STATUS_OFS |=> o_rd_data == {7'h00, !$past(i_irq_active)})
      else $error("status byte wrong");
  a_rsvd_byte_zero:
    assert property (i_rd.rd_en && i_rd.addr == RSVD_OFS |=> o_rd_data == 8'h00) else $error("reserved byte set");
  a_event_gap_zero:
    assert property (i_rd.rd_en && i_rd.addr == EVENT_OFS |=> o_rd_data[5:3] == 3'h0)
      else $error("reserved event bits set");
  a_event_latches:
    assert property (i_event != 4'h0 |=> o_any_flag) else $error("event not latched");
  a_temp_latches:
    assert property (i_thr[MON_TEMP] != 4'h0 |=> o_any_flag) else $error("threshold not latched");
  a_set_beats_clear:
    assert property (i_rd.rd_en && i_rd.addr == EVENT_OFS && i_event.main_fw_fail |=> o_any_flag)
      else $error("event lost on clear");
  c_event_read: cover property (i_rd.rd_en && i_rd.addr == EVENT_OFS ##1 o_rd_data != 8'h00);
  c_flag_cleared: cover property (o_any_flag ##1 !o_any_flag);
  c_race: cover property (i_rd.rd_en && i_event != 4'h0);
endmodule : flag_bank_chk

bind module_level_latched_flags flag_bank_chk i_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rd(i_rd),
  .i_event(i_event), .i_thr(i_thr), .i_irq_active(i_irq_active), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .o_any_flag(o_any_flag));

//--- dv/host_model.sv
// Host management controller model issuing byte reads.
`timescale 1ns/1ps
module host_model
  import flag_bank_pkg::*;
(
  input  wire logic              i_clock,    // Clock
  input  wire logic [DATA_W-1:0] i_rd_data,  // Returned byte
  input  wire logic              i_rd_valid, // Returned strobe
  output mgmt_read_t             o_rd        // Read request
);
  initial o_rd = '{rd_en: 1'b0, addr: 8'h5a};
  // Reads the flag byte itself, which is what clears it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clock);
    o_rd = '{rd_en: 1'b1, addr: a};
    @(negedge i_clock);
    v = i_rd_valid;
    d = i_rd_data;
    // Idle address inverted so a stale value is never mistaken for a live one
    o_rd = '{rd_en: 1'b0, addr: ~a};
  endtask : rd
endmodule : host_model

//--- dv/tb_top.sv
// Self-checking bench for the latched flag bank.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top
  import flag_bank_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  mgmt_read_t         rd;
  module_event_t      ev = '0;
  logic [PHASE_W-1:0] phase = '0;
  threshold_t         thr [NUM_MON] = '{default: '0};
  logic [DATA_W-1:0]  vset = '0, vvld = '0, rdata, d;
  logic               irq = 1'b0, rvld, anyf, v;
  int                 fails = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  host_model i_host (.i_clock(clk), .i_rd_data(rdata), .i_rd_valid(rvld), .o_rd(rd));
  module_level_latched_flags i_dut (.i_clock(clk), .i_rst_n(rst_n), .i_rd(rd), .i_event(ev), .i_phase(phase),
    .i_thr(thr), .i_vendor_set(vset), .i_vendor_valid(vvld), .i_irq_active(irq), .o_rd_data(rdata),
    .o_rd_valid(rvld), .o_any_flag(anyf));
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d, v);
    `CHK("valid", 1'b1, v)
    `CHK("data", e, d)
  endtask : rd_chk
  task automatic t_reset;
    for (int a = 8; a < 14; a++) rd_chk(8'(a), 8'h00);
    rd_chk(STATUS_OFS, 8'h01);
    rd_chk(8'h40, 8'h00);
    irq = 1'b1;
    rd_chk(STATUS_OFS, 8'h00);
    irq = 1'b0;
    $display("t_reset done");
  endtask : t_reset
  task automatic t_events;
    for (int b = 0; b < 4; b++)
    begin
      ev = module_event_t'(4'h8 >> b);
      @(negedge clk);
      ev = '0;
      `CHK("any", 1'b1, anyf)
      rd_chk(EVENT_OFS, b < 2 ? 8'h80 >> b : 8'h04 >> (b - 2));
      rd_chk(EVENT_OFS, 8'h00);
    end
    phase = 3'h3;
    @(negedge clk);
    rd_chk(EVENT_OFS, 8'h01);
    `CHK("any", 1'b0, anyf)
    $display("t_events done");
  endtask : t_events
  task automatic t_thresh;
    // Pattern 1100 tells the nibble order apart from its reverse
    for (int m = 0; m < NUM_MON; m++)
    begin
      thr[m] = 4'hc;
      @(negedge clk);
      thr[m] = 4'h0;
      rd_chk(8'(9 + m / 2), 8'(8'h0c << 4 * (m % 2)));
      rd_chk(8'(9 + m / 2), 8'h00);
    end
    $display("t_thresh done");
  endtask : t_thresh
  task automatic t_race_vendor;
    fork
      rd_chk(EVENT_OFS, 8'h00);
      begin
        @(negedge clk);
        ev.main_fw_fail = 1'b1;
        @(negedge clk);
        ev = '0;
      end
    join
    rd_chk(EVENT_OFS, 8'h02);
    vvld = 8'h0f;
    vset = 8'hff;
    @(negedge clk);
    vset = 8'h00;
    rd_chk(VEND_OFS, 8'h0f);
    rd_chk(VEND_OFS, 8'h00);
    rd_chk(RSVD_OFS, 8'h00);
    $display("t_race_vendor done");
  endtask : t_race_vendor
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_events();
    t_thresh();
    t_race_vendor();
    final_report();
  end
  // Whole run needs about 92 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      final_report();
    end
  end
endmodule : tb_top
